// ---- fcx_params.svh ----
// Constants for the serial flash command front-end: codes, byte positions and reset values.
`ifndef FCX_PARAMS_SVH
`define FCX_PARAMS_SVH

`define FCX_OP_ACTIVATE 8'h9B
`define FCX_SUB_CRC 8'h27
`define FCX_OPT_RANGE 8'hFE
// Fast read opcode: value arbitrary, adjust to the command set in use.
`define FCX_OP_FAST_READ 8'h0B

`define FCX_BYTE_SUB 5'h02
`define FCX_BYTE_OPT 5'h03
`define FCX_BYTE_CRC_FIRST 5'h04
`define FCX_BYTE_CRC_LAST 5'h0B
`define FCX_BYTE_SADR_FIRST 5'h0C
`define FCX_BYTE_SADR_LAST 5'h0F
`define FCX_BYTE_EADR_FIRST 5'h10
`define FCX_BYTE_EADR_LAST 5'h13
`define FCX_SEQ_LEN 5'h13
`define FCX_XIP_FIRST 5'h01
`define FCX_RD_LAST3 5'h04
`define FCX_RD_LAST4 5'h05
`define FCX_BYTE_ZERO 5'h00
`define FCX_BYTE_ONE 5'h01

`define FCX_W1 2'h0
`define FCX_W2 2'h1
`define FCX_W4 2'h2
`define FCX_BPC1 4'h1
`define FCX_BPC2 4'h2
`define FCX_BPC4 4'h4
`define FCX_BITS_ZERO 3'h0

`define FCX_VCR_XIP_RST 1'b1
`define FCX_NV_XIP_OFF 3'h7
`define FCX_SECT_W 10
`define FCX_CRC_W 64
`define FCX_ADR_W 32

`endif

// ---- fcx_pkg.sv ----
// Types shared by the flash command front-end: device states, command classes, parser states.
package fcx_pkg;

    typedef enum {DEV_STANDBY, DEV_BUSY, DEV_PSUSP, DEV_ESUSP} fcx_dev_t;

    typedef enum {
        CMD_RD_ARRAY, CMD_RD_STATUS, CMD_PROGRAM, CMD_ERASE, CMD_WR_NV,
        CMD_WR_VCR, CMD_CLR_FSR, CMD_WR_VOL, CMD_SUSPEND
    } fcx_cmd_t;

    typedef enum {PS_IDLE, PS_OPCODE, PS_CRC_SEQ, PS_RD_ADDR, PS_RD_DUMMY, PS_IGNORE} fcx_parse_t;

endpackage : fcx_pkg

// ---- fcx_gate.sv ----
// Accept or reject table for operations against the current device state.
`timescale 1ns/1ps
`include "fcx_params.svh"

module fcx_gate (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic req_valid,
    input fcx_pkg::fcx_cmd_t req_class,
    input wire logic [`FCX_SECT_W-1:0] req_sector,
    input fcx_pkg::fcx_dev_t dev_state,
    input wire logic [`FCX_SECT_W-1:0] susp_sector,
    output logic accept_q,
    output logic reject_q,
    output logic unsure_q
);

    wire in_stby = (dev_state == fcx_pkg::DEV_STANDBY);
    wire in_busy = (dev_state == fcx_pkg::DEV_BUSY);
    wire in_esusp = (dev_state == fcx_pkg::DEV_ESUSP);
    // Sector matters only in erase suspend; elsewhere the answer is the same for every sector.
    wire same_sec = in_esusp && (req_sector == susp_sector);
    logic allow;

    always_comb begin
        case (req_class)
            fcx_pkg::CMD_RD_ARRAY: allow = !in_busy;
            fcx_pkg::CMD_RD_STATUS: allow = 1'b1;
            fcx_pkg::CMD_PROGRAM: allow = in_stby || (in_esusp && !same_sec);
            fcx_pkg::CMD_ERASE: allow = in_stby;
            fcx_pkg::CMD_WR_NV: allow = in_stby;
            fcx_pkg::CMD_WR_VCR: allow = !in_busy;
            fcx_pkg::CMD_CLR_FSR: allow = !in_busy;
            fcx_pkg::CMD_WR_VOL: allow = !in_busy;
            fcx_pkg::CMD_SUSPEND: allow = in_busy;
            default: allow = 1'b0;
        endcase
    end

    wire unsure = (req_class == fcx_pkg::CMD_RD_ARRAY) && same_sec;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            accept_q <= 1'b0;
            reject_q <= 1'b0;
            unsure_q <= 1'b0;
        end else if (ce) begin
            accept_q <= req_valid && allow;
            reject_q <= req_valid && !allow;
            unsure_q <= req_valid && unsure;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    status_always_a: assert property (ce && req_valid && req_class == fcx_pkg::CMD_RD_STATUS |=> accept_q)
        else $error("status read was not accepted");
    esusp_sector_a: assert property (ce && req_valid && req_class == fcx_pkg::CMD_PROGRAM && in_esusp
        |=> (reject_q == $past(req_sector == susp_sector)) && (accept_q != reject_q))
        else $error("program in erase suspend mishandled the suspended sector");
    erase_stby_a: assert property (ce && req_valid && req_class == fcx_pkg::CMD_ERASE |=> accept_q == $past(in_stby))
        else $error("sector erase gated against the wrong state");
    suspend_busy_a: assert property (ce && req_valid && req_class == fcx_pkg::CMD_SUSPEND |=> accept_q == $past(in_busy))
        else $error("suspend gated against the wrong state");
    read_busy_a: assert property (ce && req_valid && req_class == fcx_pkg::CMD_RD_ARRAY && in_busy |=> reject_q && !accept_q)
        else $error("array read accepted while busy");

endmodule : fcx_gate

// ---- fcx_front.sv ----
// Serial flash command front-end: range CRC parsing, state gating and execute-in-place control.
`timescale 1ns/1ps
`include "fcx_params.svh"

// Contract
// - Range CRC starts with activation code, CRC sub-command, then range option byte.
// - Eight expected CRC bytes follow, least significant byte first.
// - Bytes twelve to fifteen give the 32-bit start address, low byte first.
// - Bytes sixteen to nineteen give the 32-bit end address, low byte first.
// - Chip select rising after the last address byte starts the CRC.
// - One device state at a time; standby accepts everything but suspend.
// - Outside erase suspend, accept or reject never depends on target sector.
// - In erase suspend, programs to the suspended sector are rejected, others accepted.
// - Array reads accepted in standby and suspends, rejected while busy.
// - Read to the erase-suspended sector is accepted but data may be invalid.
// - Status and flag status reads are accepted in every state.
// - Programs accepted only in standby and erase suspend.
// - Sector and subsector erase accepted only in standby.
// - Status, nonvolatile config writes, OTP program, bulk erase: standby only.
// - Volatile writes, enable, flag clear, lock writes rejected only while busy.
// - Program or erase suspend accepted only while busy.
// - Volatile bit 3 clear, then confirmation 0 on fast read enters address-only mode.
// - In address-only mode each frame starts with address bits, current width.
// - Confirmation bit 1 leaves address-only mode and sets volatile bit 3 again.
// - Basic variant enters address-only mode on confirmation 0, no config bit.
// - Nonvolatile bits 11 to 9 can boot straight into address-only mode.
// - Confirmation bit is line zero in the first dummy clock; others ignored.
// - End address below start address aborts the CRC and sets flag bit 1.
// - CRC mismatch against the expected value sets flag bit 4.
// - Suspend during CRC sets flag bit 2; cleared when the CRC finishes.
module fcx_front (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic chip_sel_n,
    input wire logic ser_clk,
    input wire logic [3:0] ser_data,
    input wire logic [1:0] proto_width,
    input wire logic addr4,
    input wire logic basic_xip,
    input wire logic [2:0] nv_xip_boot,
    input wire logic cmd_valid,
    input fcx_pkg::fcx_cmd_t cmd_class,
    input wire logic [`FCX_SECT_W-1:0] cmd_sector,
    input wire logic cmd_vcr_xip_n,
    input fcx_pkg::fcx_dev_t dev_state,
    input wire logic [`FCX_SECT_W-1:0] susp_sector,
    input wire logic crc_done,
    input wire logic [`FCX_CRC_W-1:0] crc_value,
    output logic xip_active_q,
    output logic vcr_xip_n_q,
    output logic crc_go_q,
    output logic crc_busy_q,
    output logic [`FCX_CRC_W-1:0] crc_exp_q,
    output logic [`FCX_ADR_W-1:0] crc_start_q,
    output logic [`FCX_ADR_W-1:0] crc_end_q,
    output logic fsr_range_err_q,
    output logic fsr_mismatch_q,
    output logic fsr_susp_q,
    output logic cmd_accept_q,
    output logic cmd_reject_q,
    output logic rd_unsure_q
);

    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic ck_s1_q, ck_s2_q, ck_s3_q;
    logic [3:0] dq_s1_q, dq_s2_q;
    logic [7:0] sh_q;
    logic [2:0] bitcnt_q;
    logic [4:0] bytes_q;
    logic [4:0] bytes_d;
    logic boot_pend_q;
    logic pend_vcr_q;
    fcx_pkg::fcx_cmd_t pend_cls_q;
    fcx_pkg::fcx_parse_t ps_q, ps_d;

    // Pin inputs pass two flip-flops; the third stage feeds only the edge detectors.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            ck_s1_q <= 1'b0;
            ck_s2_q <= 1'b0;
            ck_s3_q <= 1'b0;
            dq_s1_q <= 4'h0;
            dq_s2_q <= 4'h0;
        end else if (ce) begin
            cs_s1_q <= chip_sel_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            ck_s1_q <= ser_clk;
            ck_s2_q <= ck_s1_q;
            ck_s3_q <= ck_s2_q;
            dq_s1_q <= ser_data;
            dq_s2_q <= dq_s1_q;
        end
    end

    wire cs_fall = !cs_s2_q && cs_s3_q;
    wire cs_rise = cs_s2_q && !cs_s3_q;
    wire sclk_rise = ck_s2_q && !ck_s3_q && !cs_s2_q;

    // Bits per serial clock follow the enabled protocol width.
    wire [3:0] bpc = (proto_width == `FCX_W4) ? `FCX_BPC4 :
                     (proto_width == `FCX_W2) ? `FCX_BPC2 : `FCX_BPC1;
    wire [7:0] new_byte = (proto_width == `FCX_W4) ? {sh_q[3:0], dq_s2_q[3:0]} :
                          (proto_width == `FCX_W2) ? {sh_q[5:0], dq_s2_q[1:0]} :
                          {sh_q[6:0], dq_s2_q[0]};
    wire [3:0] bit_sum = {1'b0, bitcnt_q} + bpc;
    wire byte_done = sclk_rise && bit_sum[3];
    wire [4:0] cur_no = bytes_q + `FCX_BYTE_ONE;

    wire in_crc = (ps_q == fcx_pkg::PS_CRC_SEQ);
    wire cap_crc = in_crc && byte_done && (cur_no >= `FCX_BYTE_CRC_FIRST) &&
                   (cur_no <= `FCX_BYTE_CRC_LAST);
    wire cap_sadr = in_crc && byte_done && (cur_no >= `FCX_BYTE_SADR_FIRST) &&
                    (cur_no <= `FCX_BYTE_SADR_LAST);
    wire cap_eadr = in_crc && byte_done && (cur_no >= `FCX_BYTE_EADR_FIRST) &&
                    (cur_no <= `FCX_BYTE_EADR_LAST);
    // Sub-command and option must match; a twentieth byte spoils the sequence.
    wire crc_byte_ok = (cur_no == `FCX_BYTE_SUB) ? (new_byte == `FCX_SUB_CRC) :
                       (cur_no == `FCX_BYTE_OPT) ? (new_byte == `FCX_OPT_RANGE) :
                       (cur_no <= `FCX_SEQ_LEN);
    wire last_adr = cur_no == (addr4 ? `FCX_RD_LAST4 : `FCX_RD_LAST3);
    wire dummy_tick = (ps_q == fcx_pkg::PS_RD_DUMMY) && sclk_rise;
    wire conf_bit = dq_s2_q[0];
    wire crc_confirm = cs_rise && in_crc && (bytes_q == `FCX_SEQ_LEN);
    wire range_bad = crc_end_q < crc_start_q;
    wire crc_fail = crc_done && crc_busy_q && (crc_value != crc_exp_q);
    wire susp_req = cmd_valid && (cmd_class == fcx_pkg::CMD_SUSPEND);
    wire clr_ok = cmd_accept_q && (pend_cls_q == fcx_pkg::CMD_CLR_FSR);
    wire vcr_ok = cmd_accept_q && (pend_cls_q == fcx_pkg::CMD_WR_VCR);
    wire xip_may = !vcr_xip_n_q || basic_xip || xip_active_q;
    wire counting = (ps_q == fcx_pkg::PS_OPCODE) || in_crc || (ps_q == fcx_pkg::PS_RD_ADDR);

    always_comb begin
        ps_d = ps_q;
        case (ps_q)
            fcx_pkg::PS_IDLE: begin
                // In address-only mode a frame carries no opcode and begins with the address.
                if (cs_fall) ps_d = xip_active_q ? fcx_pkg::PS_RD_ADDR : fcx_pkg::PS_OPCODE;
            end
            fcx_pkg::PS_OPCODE: begin
                if (byte_done) begin
                    if (new_byte == `FCX_OP_ACTIVATE) ps_d = fcx_pkg::PS_CRC_SEQ;
                    else if (new_byte == `FCX_OP_FAST_READ) ps_d = fcx_pkg::PS_RD_ADDR;
                    else ps_d = fcx_pkg::PS_IGNORE;
                end
            end
            fcx_pkg::PS_CRC_SEQ: begin
                if (byte_done && !crc_byte_ok) ps_d = fcx_pkg::PS_IGNORE;
            end
            fcx_pkg::PS_RD_ADDR: begin
                if (byte_done && last_adr) ps_d = fcx_pkg::PS_RD_DUMMY;
            end
            fcx_pkg::PS_RD_DUMMY: begin
                if (sclk_rise) ps_d = fcx_pkg::PS_IGNORE;
            end
            fcx_pkg::PS_IGNORE: begin
                ps_d = fcx_pkg::PS_IGNORE;
            end
            default: ps_d = fcx_pkg::PS_IDLE;
        endcase
        // Chip select high ends every frame; an unfinished CRC sequence is simply dropped.
        if (cs_rise) ps_d = fcx_pkg::PS_IDLE;
    end

    always_comb begin
        bytes_d = bytes_q;
        if (cs_fall) bytes_d = xip_active_q ? `FCX_XIP_FIRST : `FCX_BYTE_ZERO;
        else if (byte_done && counting) bytes_d = cur_no;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ps_q <= fcx_pkg::PS_IDLE;
            sh_q <= 8'h00;
            bitcnt_q <= `FCX_BITS_ZERO;
            bytes_q <= `FCX_BYTE_ZERO;
        end else if (ce) begin
            ps_q <= ps_d;
            bytes_q <= bytes_d;
            if (cs_fall) begin
                sh_q <= 8'h00;
                bitcnt_q <= `FCX_BITS_ZERO;
            end else if (sclk_rise) begin
                sh_q <= new_byte;
                bitcnt_q <= bit_sum[2:0];
            end
        end
    end

    // Least significant byte arrives first, so each field shifts in from the top.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            crc_exp_q <= 64'h0000_0000_0000_0000;
            crc_start_q <= 32'h0000_0000;
            crc_end_q <= 32'h0000_0000;
        end else if (ce) begin
            if (cap_crc) crc_exp_q <= {new_byte, crc_exp_q[63:8]};
            if (cap_sadr) crc_start_q <= {new_byte, crc_start_q[31:8]};
            if (cap_eadr) crc_end_q <= {new_byte, crc_end_q[31:8]};
        end
    end

    // A confirmation that arrives while a check is still running is not started.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            crc_go_q <= 1'b0;
            crc_busy_q <= 1'b0;
        end else if (ce) begin
            crc_go_q <= crc_confirm && !range_bad && !crc_busy_q;
            if (crc_confirm && !range_bad && !crc_busy_q) crc_busy_q <= 1'b1;
            else if (crc_done) crc_busy_q <= 1'b0;
        end
    end

    // Hardware events win over a flag clear in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fsr_range_err_q <= 1'b0;
            fsr_mismatch_q <= 1'b0;
            fsr_susp_q <= 1'b0;
        end else if (ce) begin
            if (crc_confirm && range_bad) fsr_range_err_q <= 1'b1;
            else if (clr_ok) fsr_range_err_q <= 1'b0;
            if (crc_fail) fsr_mismatch_q <= 1'b1;
            else if (clr_ok) fsr_mismatch_q <= 1'b0;
            // The check cannot be suspended; the flag only records the request.
            if (crc_done && crc_busy_q) fsr_susp_q <= 1'b0;
            else if (susp_req && crc_busy_q) fsr_susp_q <= 1'b1;
        end
    end

    // The boot setting is caught on the first enabled cycle after reset release.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            boot_pend_q <= 1'b1;
            xip_active_q <= 1'b0;
            vcr_xip_n_q <= `FCX_VCR_XIP_RST;
        end else if (ce) begin
            boot_pend_q <= 1'b0;
            if (boot_pend_q) begin
                xip_active_q <= (nv_xip_boot != `FCX_NV_XIP_OFF);
            end else if (dummy_tick && conf_bit) begin
                xip_active_q <= 1'b0;
                if (xip_active_q) vcr_xip_n_q <= 1'b1;
            end else if (dummy_tick && xip_may) begin
                xip_active_q <= 1'b1;
            end
            if (vcr_ok && !dummy_tick) vcr_xip_n_q <= pend_vcr_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_cls_q <= fcx_pkg::CMD_RD_STATUS;
            pend_vcr_q <= `FCX_VCR_XIP_RST;
        end else if (ce) begin
            pend_cls_q <= cmd_class;
            pend_vcr_q <= cmd_vcr_xip_n;
        end
    end

    fcx_gate u_gate (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .req_valid(cmd_valid),
        .req_class(cmd_class),
        .req_sector(cmd_sector),
        .dev_state(dev_state),
        .susp_sector(susp_sector),
        .accept_q(cmd_accept_q),
        .reject_q(cmd_reject_q),
        .unsure_q(rd_unsure_q)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_confirm_ok;
        ce && crc_confirm && !range_bad && !crc_busy_q;
    endsequence
    sequence s_started;
        crc_go_q && crc_busy_q ##1 !crc_go_q;
    endsequence
    sequence s_last_sadr;
        ce && cap_sadr && cur_no == `FCX_BYTE_SADR_LAST;
    endsequence

    crc_start_a: assert property (s_confirm_ok |=> s_started)
        else $error("confirmed range check did not start once");
    go_cause_a: assert property (crc_go_q |-> $past(crc_confirm) && crc_end_q >= crc_start_q)
        else $error("check started without a valid confirmation");
    range_abort_a: assert property (ce && crc_confirm && range_bad |=> fsr_range_err_q && !crc_go_q)
        else $error("reversed range did not abort");
    exp_byte_a: assert property (ce && cap_crc && cur_no == `FCX_BYTE_CRC_LAST
        |=> crc_exp_q[63:56] == $past(new_byte))
        else $error("last expected byte not in top lane");
    start_addr_a: assert property (s_last_sadr |=> crc_start_q[31:24] == $past(new_byte))
        else $error("start address high byte misplaced");
    mismatch_flag_a: assert property (ce && crc_fail |=> fsr_mismatch_q)
        else $error("mismatch flag not set");
    susp_flag_a: assert property (ce && susp_req && crc_busy_q && !crc_done
        |=> fsr_susp_q ##1 (fsr_susp_q || $past(crc_done)))
        else $error("suspend flag not held during check");
    susp_clear_a: assert property (ce && crc_done && crc_busy_q |=> !fsr_susp_q && !crc_busy_q)
        else $error("suspend flag not cleared at end of check");
    xip_exit_a: assert property (ce && !boot_pend_q && dummy_tick && conf_bit
        |=> !xip_active_q && (vcr_xip_n_q || !$past(xip_active_q)))
        else $error("confirmation one did not leave address-only mode");
    xip_enter_a: assert property (ce && !boot_pend_q && dummy_tick && !conf_bit
        && (!vcr_xip_n_q || basic_xip) |=> xip_active_q)
        else $error("confirmation zero did not enter address-only mode");

endmodule : fcx_front

// ---- fcx_host_model.sv ----
// Host controller model that drives chip select, serial clock and data lines of the front-end.
`timescale 1ns/1ps

module fcx_host_model (
    input wire logic ref_clk,
    output logic chip_sel_n,
    output logic ser_clk,
    output logic [3:0] ser_data
);
    initial begin
        chip_sel_n = 1'b1;
        ser_clk = 1'b0;
        ser_data = 4'h5;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    // Each clock phase lasts four reference cycles, above the three the synchroniser needs.
    task automatic frame_begin;
        tick(1);
        chip_sel_n <= 1'b0;
        tick(4);
    endtask : frame_begin

    // Unused lines carry the inverse of line zero so a design that reads them is caught.
    task automatic send(input logic [63:0] val, input int nbits);
        for (int i = nbits - 1; i >= 0; i--) begin
            ser_data <= {~{3{val[i]}}, val[i]};
            tick(4);
            ser_clk <= 1'b1;
            tick(4);
            ser_clk <= 1'b0;
        end
    endtask : send

    task automatic frame_end;
        tick(4);
        chip_sel_n <= 1'b1;
        ser_data <= ~ser_data;
    endtask : frame_end
endmodule : fcx_host_model

// ---- testbench.sv ----
// Self-checking bench for the flash command front-end.
`timescale 1ns/1ps
`include "fcx_params.svh"
`define CHECK(g, e) chk(64'(g), 64'(e))

module testbench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic chip_sel_n, ser_clk;
    logic [3:0] ser_data;
    logic basic_xip = 1'b0;
    logic [2:0] nv_xip_boot = 3'h7;
    logic cmd_valid = 1'b0;
    fcx_pkg::fcx_cmd_t cmd_class = fcx_pkg::CMD_RD_STATUS;
    logic [9:0] cmd_sector = 10'h001;
    logic cmd_vcr_xip_n = 1'b1;
    fcx_pkg::fcx_dev_t dev_state = fcx_pkg::DEV_STANDBY;
    logic [9:0] susp_sector = 10'h005;
    logic crc_done = 1'b0;
    logic [63:0] crc_value = 64'h0, crc_exp_q;
    logic [31:0] crc_start_q, crc_end_q;
    logic xip_active_q, vcr_xip_n_q, crc_go_q, crc_busy_q, fsr_range_err_q, fsr_mismatch_q;
    logic fsr_susp_q, cmd_accept_q, cmd_reject_q, rd_unsure_q;
    int n_mismatch = 0;
    int compares = 0;
    int n_go = 0;
    int cyc = 0;

    always #12.5 ref_clk = ~ref_clk;

    fcx_host_model u_fcx_host_model (.ref_clk(ref_clk), .chip_sel_n(chip_sel_n),
        .ser_clk(ser_clk), .ser_data(ser_data));

    fcx_front u_fcx_front (.ref_clk(ref_clk), .rst(rst), .ce(ce), .chip_sel_n(chip_sel_n),
        .ser_clk(ser_clk), .ser_data(ser_data), .proto_width(`FCX_W1), .addr4(1'b0),
        .basic_xip(basic_xip), .nv_xip_boot(nv_xip_boot), .cmd_valid(cmd_valid),
        .cmd_class(cmd_class), .cmd_sector(cmd_sector), .cmd_vcr_xip_n(cmd_vcr_xip_n),
        .dev_state(dev_state), .susp_sector(susp_sector), .crc_done(crc_done),
        .crc_value(crc_value), .xip_active_q(xip_active_q), .vcr_xip_n_q(vcr_xip_n_q),
        .crc_go_q(crc_go_q), .crc_busy_q(crc_busy_q), .crc_exp_q(crc_exp_q),
        .crc_start_q(crc_start_q), .crc_end_q(crc_end_q), .fsr_range_err_q(fsr_range_err_q),
        .fsr_mismatch_q(fsr_mismatch_q), .fsr_susp_q(fsr_susp_q),
        .cmd_accept_q(cmd_accept_q), .cmd_reject_q(cmd_reject_q), .rd_unsure_q(rd_unsure_q));

    task automatic print_verdict;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    always @(posedge ref_clk) begin
        cyc++;
        if (crc_go_q === 1'b1) n_go++;
        if (cyc == 60000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    // Outputs are looked at one step after the answering edge, once its updates have landed.
    task automatic req(input fcx_pkg::fcx_cmd_t c, input fcx_pkg::fcx_dev_t s,
                       input logic [9:0] sec, output logic [2:0] ans);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_class <= c;
        dev_state <= s;
        cmd_sector <= sec;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        #1;
        ans = {cmd_accept_q, cmd_reject_q, rd_unsure_q};
    endtask : req

    task automatic sendb(input logic [63:0] v, input int nbytes);
        for (int k = 0; k < nbytes; k++) u_fcx_host_model.send(v[8*k+:8], 8);
    endtask : sendb

    task automatic crc_frame(input logic [63:0] e, input logic [31:0] sa, input logic [31:0] ea);
        u_fcx_host_model.frame_begin();
        sendb(64'(`FCX_OP_ACTIVATE), 1);
        sendb(64'(`FCX_SUB_CRC), 1);
        sendb(64'(`FCX_OPT_RANGE), 1);
        sendb(e, 8);
        sendb(64'(sa), 4);
        sendb(64'(ea), 4);
        u_fcx_host_model.frame_end();
        tick(8);
    endtask : crc_frame

    task automatic fast_rd(input logic conf, input logic with_op);
        u_fcx_host_model.frame_begin();
        if (with_op) sendb(64'(`FCX_OP_FAST_READ), 1);
        sendb(64'h0001_2345, 3);
        u_fcx_host_model.send(64'(conf), 1);
        u_fcx_host_model.frame_end();
        tick(4);
    endtask : fast_rd

    task automatic t_gate;
        logic [3:0] m [9] = '{4'hD, 4'hF, 4'h9, 4'h1, 4'h1, 4'hD, 4'hD, 4'hD, 4'h2};
        logic [2:0] a;
        for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 9; c++) begin
                req(fcx_pkg::fcx_cmd_t'(c), fcx_pkg::fcx_dev_t'(s), 10'h001, a);
                `CHECK(a[2:1], m[c][s] ? 2'h2 : 2'h1);
                req(fcx_pkg::fcx_cmd_t'(c), fcx_pkg::fcx_dev_t'(s), 10'h3F0, a);
                `CHECK(a[2:1], m[c][s] ? 2'h2 : 2'h1);
            end
        end
        req(fcx_pkg::CMD_PROGRAM, fcx_pkg::DEV_ESUSP, 10'h005, a);
        `CHECK(a[2:1], 2'h1);
        req(fcx_pkg::CMD_RD_ARRAY, fcx_pkg::DEV_ESUSP, 10'h005, a);
        `CHECK(a, 3'h5);
    endtask : t_gate

    task automatic t_crc;
        logic [2:0] a;
        int g0 = n_go;
        crc_frame(64'h0123_4567_89AB_CDEF, 32'h0000_1000, 32'h0000_1FFF);
        `CHECK(crc_exp_q, 64'h0123_4567_89AB_CDEF);
        `CHECK({crc_start_q, crc_end_q}, 64'h0000_1000_0000_1FFF);
        `CHECK({n_go - g0, crc_busy_q}, 2'h3);
        req(fcx_pkg::CMD_SUSPEND, fcx_pkg::DEV_STANDBY, 10'h001, a);
        tick(1);
        `CHECK(fsr_susp_q, 1'b1);
        crc_value <= 64'h0;
        crc_done <= 1'b1;
        tick(1);
        crc_done <= 1'b0;
        tick(2);
        `CHECK({crc_busy_q, fsr_susp_q, fsr_mismatch_q}, 3'h1);
        g0 = n_go;
        crc_frame(64'h0, 32'h0000_2000, 32'h0000_1FFF);
        `CHECK({n_go - g0, fsr_range_err_q}, 2'h1);
        req(fcx_pkg::CMD_CLR_FSR, fcx_pkg::DEV_BUSY, 10'h001, a);
        tick(2);
        `CHECK({fsr_range_err_q, fsr_mismatch_q}, 2'h3);
        req(fcx_pkg::CMD_CLR_FSR, fcx_pkg::DEV_STANDBY, 10'h001, a);
        tick(2);
        `CHECK({fsr_range_err_q, fsr_mismatch_q}, 2'h0);
    endtask : t_crc

    task automatic t_xip;
        logic [2:0] a;
        cmd_vcr_xip_n <= 1'b0;
        req(fcx_pkg::CMD_WR_VCR, fcx_pkg::DEV_STANDBY, 10'h001, a);
        tick(2);
        `CHECK(vcr_xip_n_q, 1'b0);
        cmd_vcr_xip_n <= 1'b1;
        fast_rd(1'b0, 1'b1);
        `CHECK(xip_active_q, 1'b1);
        fast_rd(1'b1, 1'b0);
        `CHECK({xip_active_q, vcr_xip_n_q}, 2'h1);
        fast_rd(1'b0, 1'b1);
        `CHECK(xip_active_q, 1'b0);
        basic_xip <= 1'b1;
        fast_rd(1'b0, 1'b1);
        `CHECK(xip_active_q, 1'b1);
        fast_rd(1'b1, 1'b0);
        `CHECK(xip_active_q, 1'b0);
        basic_xip <= 1'b0;
        nv_xip_boot <= 3'h0;
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(3);
        `CHECK(xip_active_q, 1'b1);
        fast_rd(1'b1, 1'b0);
        `CHECK(xip_active_q, 1'b0);
    endtask : t_xip

    initial begin
        tick(20);
        rst <= 1'b0;
        tick(3);
        `CHECK({xip_active_q, vcr_xip_n_q, crc_busy_q, fsr_range_err_q}, 4'h4);
        t_gate();
        t_crc();
        t_xip();
        print_verdict();
    end
endmodule : testbench
